// file: sasr_readout.sv
// conversion sequencing and serial result readout of a sampling converter
`timescale 1ns/1ps
`include "sasr_defs.svh"

module sasr_readout #(
   parameter int WIDTH = `SASR_RESULT_BITS
) (
   input  wire logic               sys_clk_i,
   input  wire logic               reset_i,
   input  wire logic               sclk_i,
   input  wire logic               cs_n_i,
   input  wire logic [WIDTH-1:0]   conv_word_i,
   output sasr_pkg::sasr_link_t    link_o,
   output logic                    sampling_o,
   output logic                    hold_o,
   output logic                    power_down_o,
   output logic                    busy_o
);

   if (WIDTH != `SASR_RESULT_BITS) begin : g_width_check
      $error("sasr_readout: frame positions serve only a 12-bit result");
   end

   // ---------------------------------------------------------------
   // pin synchronisers and edge detect
   // ---------------------------------------------------------------
   logic sclk_meta_reg;
   logic sclk_sync_reg;
   logic sclk_prev_reg;
   logic cs_n_meta_reg;
   logic cs_n_sync_reg;
   logic cs_n_prev_reg;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_meta_reg <= 1'b0;
         sclk_sync_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         cs_n_meta_reg <= 1'b1;
         cs_n_sync_reg <= 1'b1;
         cs_n_prev_reg <= 1'b1;
      end else begin
         sclk_meta_reg <= sclk_i;
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg;
         cs_n_meta_reg <= cs_n_i;
         cs_n_sync_reg <= cs_n_meta_reg;
         cs_n_prev_reg <= cs_n_sync_reg;
      end
   end

   // select chain still shows reset values for two edges after release
   logic [1:0] flush_reg;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         flush_reg <= 2'h0;
      end else begin
         flush_reg <= {flush_reg[0], 1'h1};
      end
   end

   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg;
   assign cs_fall   = cs_n_prev_reg & ~cs_n_sync_reg;
   assign cs_rise   = ~cs_n_prev_reg & cs_n_sync_reg;

   // ---------------------------------------------------------------
   // frame arming and falling-edge count
   // ---------------------------------------------------------------
   logic       armed_reg;
   logic       frame_reg;
   logic       short_reg;
   logic [4:0] fall_cnt_reg;
   logic       start;

   // select low out of reset does not start a frame
   assign start = cs_fall & armed_reg;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         armed_reg <= 1'b0;
      end else if (cs_n_sync_reg && flush_reg[1]) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         frame_reg    <= 1'b0;
         short_reg    <= 1'b0;
         fall_cnt_reg <= 5'h00;
      end else if (cs_rise) begin
         frame_reg <= 1'b0;
      end else if (start) begin
         frame_reg    <= 1'b1;
         // clock already high: first edge is a fall, frame shortens
         short_reg    <= sclk_sync_reg;
         fall_cnt_reg <= 5'h00;
      end else if (frame_reg && sclk_fall && fall_cnt_reg != `SASR_FALL_MAX) begin
         fall_cnt_reg <= fall_cnt_reg + 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // conversion sequence
   // ---------------------------------------------------------------
   sasr_pkg::sasr_state_t state_reg;
   logic [1:0]            hold_cnt_reg;
   logic [WIDTH-1:0]      word_reg;
   logic [4:0]            frame_end;

   assign frame_end = short_reg ? `SASR_FRAME_SHORT : `SASR_FRAME_FULL;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_reg    <= sasr_pkg::SASR_IDLE;
         hold_cnt_reg <= 2'h0;
         word_reg     <= '0;
      end else if (cs_rise) begin
         // a cut frame must not leave a hold count for the next one
         hold_cnt_reg <= 2'h0;
         state_reg    <= sasr_pkg::SASR_IDLE;
      end else if (start) begin
         hold_cnt_reg <= 2'h0;
         state_reg    <= sasr_pkg::SASR_SAMPLE;
      end else begin
         unique case (state_reg)
            sasr_pkg::SASR_IDLE: begin
               state_reg <= sasr_pkg::SASR_IDLE;
            end
            sasr_pkg::SASR_SAMPLE: begin
               // track until the second fall, then hold after aperture delay
               if (sclk_fall && fall_cnt_reg == `SASR_FALL_HOLD - 5'h01) begin
                  hold_cnt_reg <= 2'(`SASR_HOLD_CYCLES);
               end else if (hold_cnt_reg == 2'h1) begin
                  hold_cnt_reg <= 2'h0;
                  word_reg     <= conv_word_i;
                  state_reg    <= sasr_pkg::SASR_CONVERT;
               end else if (hold_cnt_reg != 2'h0) begin
                  hold_cnt_reg <= hold_cnt_reg - 2'h1;
               end
            end
            sasr_pkg::SASR_CONVERT: begin
               if (sclk_fall && fall_cnt_reg == frame_end - 5'h01) begin
                  state_reg <= sasr_pkg::SASR_DONE;
               end
            end
            sasr_pkg::SASR_DONE: begin
               state_reg <= sasr_pkg::SASR_DONE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // serial output
   // ---------------------------------------------------------------
   // bit driven after fall number n; oe low means high impedance
   function automatic logic [1:0] sasr_bit_at(input logic [4:0] n,
                                              input logic [WIDTH-1:0] w);
      logic [1:0] r;
      r = 2'b00;
      if (n == `SASR_FALL_HOLD) begin
         r = 2'b10;
      end else if (n >= `SASR_FALL_MSB && n <= `SASR_FALL_LSB) begin
         r = {1'b1, w[4'(`SASR_FALL_LSB - n)]};
      end else if (n > `SASR_FALL_LSB && n <= `SASR_FALL_REPEAT_END) begin
         r = {1'b1, w[4'(n - `SASR_FALL_LSB)]};
      end else if (n >= `SASR_FALL_OFF) begin
         r = 2'b00;
      end
      return r;
   endfunction

   logic [1:0] next_bit;
   assign next_bit = sasr_bit_at(fall_cnt_reg + 5'h01, word_reg);

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         link_o <= '{dout: 1'b0, dout_oe: 1'b0};
      end else if (cs_n_sync_reg || !frame_reg) begin
         link_o <= '{dout: 1'b0, dout_oe: 1'b0};
      end else if (sclk_fall && fall_cnt_reg != `SASR_FALL_MAX) begin
         // null bit at fall 2, data from fall 3, off after fall 26
         link_o <= '{dout: next_bit[0], dout_oe: next_bit[1]};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sampling_o   <= 1'b0;
         hold_o       <= 1'b0;
         power_down_o <= 1'b1;
         busy_o       <= 1'b0;
      end else begin
         sampling_o   <= (state_reg == sasr_pkg::SASR_SAMPLE) && !cs_rise;
         hold_o       <= state_reg == sasr_pkg::SASR_CONVERT;
         power_down_o <= (state_reg == sasr_pkg::SASR_IDLE) ||
                         (state_reg == sasr_pkg::SASR_DONE);
         busy_o       <= frame_reg;
      end
   end

endmodule

// file: sasr_defs.svh
// timing counts and frame positions of the serial converter readout
`ifndef SASR_DEFS_SVH
`define SASR_DEFS_SVH

`define SASR_CLK_PERIOD_NS    40
`define SASR_APERTURE_NS      6
`define SASR_HOLD_CYCLES      ((`SASR_APERTURE_NS + `SASR_CLK_PERIOD_NS - 1) / `SASR_CLK_PERIOD_NS)
`define SASR_RESULT_BITS      12
`define SASR_FALL_HOLD        5'h02
`define SASR_FALL_MSB         5'h03
`define SASR_FALL_LSB         5'h0e
`define SASR_FALL_REPEAT_END  5'h19
`define SASR_FALL_OFF         5'h1a
`define SASR_FRAME_FULL       5'h10
`define SASR_FRAME_SHORT      5'h0e
`define SASR_FALL_MAX         5'h1f

`endif

// file: sasr_pkg.sv
// types shared by the serial converter readout
package sasr_pkg;

   typedef struct packed {
      logic dout;
      logic dout_oe;
   } sasr_link_t;

   typedef enum logic [1:0] {
      SASR_IDLE    = 2'b00,
      SASR_SAMPLE  = 2'b01,
      SASR_CONVERT = 2'b11,
      SASR_DONE    = 2'b10
   } sasr_state_t;

endpackage

// file: sasr_readout_chk.sv
// port checker of the serial readout
`timescale 1ns/1ps
module sasr_readout_chk (
   input logic                 sys_clk_i,
   input logic                 reset_i,
   input logic                 sclk_i,
   input logic                 cs_n_i,
   input sasr_pkg::sasr_link_t link_o,
   input logic                 sampling_o,
   input logic                 hold_o,
   input logic                 power_down_o,
   input logic                 busy_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   AST_RST: assert property (disable iff (1'b0) reset_i |=> !link_o.dout_oe && power_down_o)
      else $error("reset state wrong");
   AST_CS_OFF: assert property (cs_n_i [*5] |-> !link_o.dout_oe && !busy_o)
      else $error("driving while deselected");
   AST_EXCL: assert property (!(sampling_o && hold_o))
      else $error("track and hold together");
   AST_HOLD_PD: assert property (hold_o |-> !power_down_o)
      else $error("power down while converting");
   AST_NULL: assert property ($rose(link_o.dout_oe) |-> !link_o.dout)
      else $error("first bit not null");
   AST_EDGE: assert property (link_o.dout_oe && $past(link_o.dout_oe)
      && $changed(link_o.dout) |-> !sclk_i)
      else $error("data changed off a fall");
   AST_HOLD: assert property ($rose(hold_o) |-> $fell(sampling_o) && link_o.dout_oe)
      else $error("hold not after second fall");
   AST_BUSY: assert property ($rose(busy_o) |-> sampling_o && !cs_n_i && !hold_o)
      else $error("frame start wrong");
   cover property ($rose(hold_o));
   cover property ($rose(link_o.dout_oe));
   cover property ($fell(busy_o));
endmodule
bind sasr_readout sasr_readout_chk u_chk (.sys_clk_i, .reset_i, .sclk_i, .cs_n_i, .link_o,
   .sampling_o, .hold_o, .power_down_o, .busy_o);

// file: sasr_host.sv
// host model: drives select and serial clock, latches output
`timescale 1ns/1ps
module sasr_host (
   input  logic                 sys_clk_i,
   input  sasr_pkg::sasr_link_t link_i,
   input  logic                 hold_i,
   input  logic                 pd_i,
   input  logic                 samp_i,
   output logic                 sclk_o,
   output logic                 cs_n_o
);
   logic cap [1:31];
   logic hd  [1:31];
   logic pd  [1:31];
   logic sp  [1:31];
   initial sclk_o = 1'b0;
   initial cs_n_o = 1'b1;
   task automatic half();
      repeat (6) @(negedge sys_clk_i);
   endtask
   // one frame of n falls; hi starts with the clock high
   task automatic frame(input int n, input bit hi);
      sclk_o = hi;
      half();
      cs_n_o = 1'b0;
      half();
      if (!hi) begin
         sclk_o = 1'b1;
         half();
      end
      for (int k = 1; k <= n; k++) begin
         sclk_o = 1'b0;
         half();
         cap[k] = link_i.dout_oe ? link_i.dout : 1'bz;
         hd[k] = hold_i;
         pd[k] = pd_i;
         sp[k] = samp_i;
         sclk_o = 1'b1;
         half();
      end
      cs_n_o = 1'b1;
      half();
      sclk_o = 1'b0;
      half();
   endtask
endmodule

// file: testbench.sv
// testbench of the serial readout
`timescale 1ns/1ps
module testbench;
   logic                 sys_clk_i = 1'b0;
   logic                 reset_i = 1'b1;
   logic                 sclk;
   logic                 cs_n;
   logic [11:0]          word = 12'h000;
   sasr_pkg::sasr_link_t link;
   logic                 samp, hold, pd, busy;
   int                   n_fail = 0;
   int                   comparisons = 0;
   sasr_readout uut (.sys_clk_i, .reset_i, .sclk_i(sclk), .cs_n_i(cs_n), .conv_word_i(word),
      .link_o(link), .sampling_o(samp), .hold_o(hold), .power_down_o(pd), .busy_o(busy));
   sasr_host host (.sys_clk_i, .link_i(link), .hold_i(hold), .pd_i(pd), .samp_i(samp),
      .sclk_o(sclk), .cs_n_o(cs_n));
   initial forever #20 sys_clk_i = ~sys_clk_i;
   task automatic chk(input string s, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic t_full(input logic [11:0] w);
      word = w;
      host.frame(26, 1'b0);
      chk("pre", 1'bz, host.cap[1]);
      chk("null", 1'b0, host.cap[2]);
      for (int k = 0; k < 12; k++) chk("msb", w[11-k], host.cap[3+k]);
      for (int k = 1; k < 12; k++) chk("lsb", w[k], host.cap[14+k]);
      chk("end", 1'bz, host.cap[26]);
      chk("track", 1'b0, host.hd[1]);
      chk("hold", 1'b1, host.hd[2]);
      chk("samp1", 1'b1, host.sp[1]);
      chk("samp2", 1'b0, host.sp[2]);
      chk("pd15", 1'b0, host.pd[15]);
      chk("pd16", 1'b1, host.pd[16]);
   endtask
   task automatic t_short(input logic [11:0] w);
      word = w;
      host.frame(14, 1'b1);
      for (int k = 0; k < 12; k++) chk("msb", w[11-k], host.cap[3+k]);
      chk("pd13", 1'b0, host.pd[13]);
      chk("pd14", 1'b1, host.pd[14]);
      chk("off", 1'b0, link.dout_oe);
      chk("busy", 1'b0, busy);
   endtask
   // reset with select low: no frame until select has been high
   task automatic t_rst_low();
      host.cs_n_o = 1'b0;
      reset_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      host.sclk_o = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      host.sclk_o = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk("rst_busy", 1'b0, busy);
      chk("rst_samp", 1'b0, samp);
      chk("rst_oe", 1'b0, link.dout_oe);
      host.cs_n_o = 1'b1;
      repeat (6) @(negedge sys_clk_i);
   endtask
   task automatic test_done();
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge sys_clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      t_full(12'ha5c);
      t_rst_low();
      t_short(12'h3a5);
      t_full(12'h801);
      test_done();
   end
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule
